// [hw/nppr_defines.vh]
// constants for the next page partner word register block
`ifndef NPPR_DEFINES_VH
`define NPPR_DEFINES_VH
// the word register index is kept; its byte address is four times the index
`define NPPR_IDX_WORD      6'h08
`define NPPR_OFF_WORD      {`NPPR_IDX_WORD, 2'h0}
`define NPPR_OFF_STATUS    8'h40
`define NPPR_OFF_BASE      8'h44
`define NPPR_WORD_RESET    16'h0000
`define NPPR_BIT_MORE      15
`define NPPR_BIT_RSVD      14
`define NPPR_BIT_MSG       13
`define NPPR_BIT_COMPLY_ACK_FLAG      12
`define NPPR_BIT_TOGGLE    11
`define NPPR_CODE_HI       10
`define NPPR_CODE_LO       0
`define NPPR_BASE_TOG_BIT  11
`define NPPR_STAT_SEEN     0
`define NPPR_STAT_EXP      1
`define NPPR_STAT_ERR      2
`define NPPR_RESP_OKAY     2'h0
`define NPPR_RESP_SLVERR   2'h2
`define NPPR_ADDR_W        8
`endif

// [hw/nppr_word_capture.v]
// captures the partner next page word and tracks the expected toggle
`timescale 1ns/100ps
`default_nettype none
`include "nppr_defines.vh"
module nppr_word_capture
(
  input  wire        ref_clk_i,
  input  wire        rst_i,
  input  wire        page_valid_i,
  input  wire [15:0] page_word_i,
  input  wire        exchange_start_i,
  input  wire        base_word_tog_i,
  output wire [15:0] word_o,
  output wire        expect_tog_o,
  output wire        tog_err_o,
  output wire        new_page_o
);
  reg [15:0] word_ff;
  reg        expect_tog_ff;
  reg        tog_err_ff;
  reg        new_page_ff;
  reg [15:0] nxt_word;

  assign word_o       = word_ff;
  assign expect_tog_o = expect_tog_ff;
  assign tog_err_o    = tog_err_ff;
  assign new_page_o   = new_page_ff;

  always @*
  begin
    nxt_word = page_word_i;
    nxt_word[`NPPR_BIT_RSVD] = 1'b0;
  end

  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      word_ff       <= `NPPR_WORD_RESET;
      expect_tog_ff <= 1'b0;
      tog_err_ff    <= 1'b0;
      new_page_ff   <= 1'b0;
    end
    else
    begin
      // a page dropped by an exchange start must not mark a new word
      new_page_ff <= page_valid_i & ~exchange_start_i;
      if (exchange_start_i)
      begin
        // first page of an exchange carries the inverse of the base word toggle
        expect_tog_ff <= ~base_word_tog_i;
        tog_err_ff    <= 1'b0;
      end
      else if (page_valid_i)
      begin
        word_ff       <= nxt_word;
        tog_err_ff    <= (page_word_i[`NPPR_BIT_TOGGLE] != expect_tog_ff);
        expect_tog_ff <= ~page_word_i[`NPPR_BIT_TOGGLE];
      end
    end
  end
endmodule
`default_nettype wire

// [hw/nppr_regs.v]
// axi4-lite register bank holding the partner next page word
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "nppr_defines.vh"
module nppr_regs
(
  input  wire        ref_clk_i,
  input  wire        rst_i,
  input  wire        page_valid_i,
  input  wire [15:0] page_word_i,
  input  wire        exchange_start_i,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  input  wire [7:0]  s_axi_araddr,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp
);
  reg        aw_ff;
  reg [7:0]  awaddr_ff;
  reg        w_ff;
  reg [31:0] wdata_ff;
  reg        base_lane_ff;
  reg        base_tog_ff;
  reg        seen_ff;
  wire [15:0] word;
  wire        expect_tog;
  wire        tog_err;
  wire        new_page;
  reg  [31:0] nxt_rdata;
  reg  [1:0]  nxt_rresp;

  nppr_word_capture u_cap
  (
    .ref_clk_i        (ref_clk_i),
    .rst_i            (rst_i),
    .page_valid_i     (page_valid_i),
    .page_word_i      (page_word_i),
    .exchange_start_i (exchange_start_i),
    .base_word_tog_i  (base_tog_ff),
    .word_o           (word),
    .expect_tog_o     (expect_tog),
    .tog_err_o        (tog_err),
    .new_page_o       (new_page)
  );

  assign s_axi_awready = ~aw_ff & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_ff & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  // write channel; the partner word register ignores writes
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      aw_ff        <= 1'b0;
      awaddr_ff    <= 8'h00;
      w_ff         <= 1'b0;
      wdata_ff     <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `NPPR_RESP_OKAY;
      base_tog_ff  <= 1'b0;
      base_lane_ff <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_ff     <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_ff     <= 1'b1;
        wdata_ff <= s_axi_wdata;
        // strobe is only valid with the data beat, so keep it with the data
        base_lane_ff <= s_axi_wstrb[`NPPR_BASE_TOG_BIT / 8];
      end
      if (aw_ff && w_ff && !s_axi_bvalid)
      begin
        aw_ff        <= 1'b0;
        w_ff         <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_ff == `NPPR_OFF_BASE)
        begin
          if (base_lane_ff)
            base_tog_ff <= wdata_ff[`NPPR_BASE_TOG_BIT];
          s_axi_bresp <= `NPPR_RESP_OKAY;
        end
        else if (awaddr_ff == `NPPR_OFF_WORD || awaddr_ff == `NPPR_OFF_STATUS)
          s_axi_bresp <= `NPPR_RESP_OKAY;
        else
          s_axi_bresp <= `NPPR_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // page-seen flag: a new word wins over the clear on status read
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      seen_ff <= 1'b0;
    else if (new_page)
      seen_ff <= 1'b1;
    else if (s_axi_arvalid && s_axi_arready && s_axi_araddr == `NPPR_OFF_STATUS)
      seen_ff <= 1'b0;
  end

  always @*
  begin
    nxt_rdata = 32'h00000000;
    nxt_rresp = `NPPR_RESP_OKAY;
    case (s_axi_araddr)
      `NPPR_OFF_WORD:   nxt_rdata[15:0] = word;
      `NPPR_OFF_STATUS:
      begin
        nxt_rdata[`NPPR_STAT_SEEN] = seen_ff;
        nxt_rdata[`NPPR_STAT_EXP]  = expect_tog;
        nxt_rdata[`NPPR_STAT_ERR]  = tog_err;
      end
      `NPPR_OFF_BASE:   nxt_rdata[`NPPR_BASE_TOG_BIT] = base_tog_ff;
      default:          nxt_rresp = `NPPR_RESP_SLVERR;
    endcase
  end

  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `NPPR_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= nxt_rdata;
      s_axi_rresp  <= nxt_rresp;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule
`default_nettype wire

// [tb/nppr_chk_asserts.sv]
// read-side assertions for the partner word register bank
`timescale 1ns/100ps
`default_nettype none
module nppr_chk
(
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic        page_valid_i,
  input wire logic [15:0] page_word_i,
  input wire logic        exchange_start_i,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic [15:0] lw_ff;
  wire         ar = s_axi_arvalid && s_axi_arready;
  // exchange start wins over a page in the same cycle
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
      lw_ff <= 16'h0000;
    else if (page_valid_i && !exchange_start_i)
      lw_ff <= page_word_i;
  property p_rlat; ar |=> s_axi_rvalid; endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_rhld; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhld: assert property (p_rhld) else $error("read data moved");
  property p_hi; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
  a_hi: assert property (p_hi) else $error("upper bits set");
  property p_rsv; s_axi_rvalid |-> !s_axi_rdata[14]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_word; ar && s_axi_araddr == 8'h20 && !page_valid_i |=>
    s_axi_rdata[15:0] == (lw_ff & 16'hBFFF) && s_axi_rresp == 2'h0; endproperty
  a_word: assert property (p_word) else $error("word mismatch");
  property p_bad; ar && !(s_axi_araddr inside {8'h20, 8'h40, 8'h44}) |=>
    s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0; endproperty
  a_bad: assert property (p_bad) else $error("unmapped read");
  property p_aref; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_aref: assert property (p_aref) else $error("second read taken");
  property p_rone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_rone: assert property (p_rone) else $error("read answered twice");
  c_word: cover property (ar && s_axi_araddr == 8'h20);
  c_page: cover property (page_valid_i);
  c_bad: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  c_stat: cover property (ar && s_axi_araddr == 8'h40);
endmodule
bind nppr_regs nppr_chk i_chk(.*);
`default_nettype wire

// [tb/nppr_lp_model.sv]
// link partner model handing over next page words
`timescale 1ns/100ps
`default_nettype none
module nppr_lp_model
(
  input  wire logic   ref_clk_i,
  output logic        page_valid_o,
  output logic [15:0] page_word_o
);
  initial page_valid_o = 0;
  initial page_word_o = 16'h0000;
  task send(input logic [15:0] w);
    @(posedge ref_clk_i);
    page_valid_o <= 1;
    page_word_o  <= w; // caller alternates the toggle
    @(posedge ref_clk_i);
    page_valid_o <= 0;
    page_word_o  <= ~w;
  endtask
endmodule
`default_nettype wire

// [tb/tb_nppr_regs.sv]
// self-checking bench for the partner word register bank
`timescale 1ns/100ps
`default_nettype none
module tb_nppr_regs;
  logic ref_clk_i = 0, rst_i = 1, exchange_start_i = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, page_valid_i, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, t, g;
  logic [2:0] rdy;
  logic [1:0] s_axi_bresp, s_axi_rresp, q;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [15:0] page_word_i, p;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, s = 32'h0F06867A, d;
  int err_count = 0, cmp_count = 0, i, k, n;
  always #25 ref_clk_i = ~ref_clk_i;
  nppr_regs i_nppr_regs(.*);
  nppr_lp_model i_nppr_lp_model(.ref_clk_i, .page_valid_o(page_valid_i), .page_word_o(page_word_i));
  task conclude;
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string m, input logic [31:0] x, input logic [31:0] y);
    cmp_count++;
    if (y !== x)
    begin
      err_count++;
      $display("[ERR] %s exp %h got %h", m, x, y);
    end
  endtask
  function logic [31:0] xs;
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // one loop serves both channels; valid drops at the edge where ready was seen
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk_i);
    if (wr)
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, v, 3'h7};
    else
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    for (n = 0; n < 40; n++)
    begin
      @(negedge ref_clk_i);
      t = wr ? s_axi_bvalid : s_axi_rvalid;
      {rdy, q, d} = {s_axi_awready, s_axi_wready, s_axi_arready, wr ? s_axi_bresp : s_axi_rresp, s_axi_rdata};
      @(posedge ref_clk_i);
      if (rdy[2] && wr)
        s_axi_awvalid <= 0;
      if (rdy[1] && wr)
        s_axi_wvalid <= 0;
      if (rdy[0] && !wr)
        s_axi_arvalid <= 0;
      if (t)
        break;
    end
    {s_axi_bready, s_axi_rready} <= 2'h0;
    if (n == 40)
    begin
      err_count++;
      conclude;
    end
  endtask
  initial
  begin
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 0;
    bus(0, 8'h20, 0);
    chk("word", 0, d);
    bus(0, 8'h10, 0);
    chk("resp", 2, q);
    chk("rdata", 0, d);
    bus(1, 8'h10, 0);
    chk("wresp", 2, q);
    $display("reset test done");
    for (i = 0; i < 3; i++)
    begin
      bus(1, 8'h44, xs());
      g = ~s[11];
      @(posedge ref_clk_i) exchange_start_i <= 1;
      @(posedge ref_clk_i) exchange_start_i <= 0;
      for (k = 0; k < 4; k++)
      begin
        p = (i == 0 && k == 0) ? 16'hFFFF : xs();
        p[11] = g;
        i_nppr_lp_model.send(p);
        g = ~g;
        bus(1, 8'h20, {16'h0000, p & 16'hBFFF} ^ 32'h7FF);
        chk("wresp", 0, q);
        bus(0, 8'h20, 0);
        chk("word", p & 16'hBFFF, d);
      end
      bus(0, 8'h40, 0);
      chk("status", {29'h0, 1'h0, g, 1'h1}, d);
    end
    $display("page test done");
    // a page with the wrong toggle flags an error; the seen flag clears on read
    p = xs();
    p[11] = ~g;
    i_nppr_lp_model.send(p);
    bus(0, 8'h40, 0);
    chk("status", {29'h0, 1'h1, g, 1'h1}, d);
    bus(0, 8'h40, 0);
    chk("status", {29'h0, 1'h1, g, 1'h0}, d);
    bus(0, 8'h20, 0);
    chk("word", p & 16'hBFFF, d);
    $display("toggle error test done");
    @(posedge ref_clk_i) rst_i <= 1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 0;
    bus(0, 8'h20, 0);
    chk("word", 0, d);
    bus(0, 8'h40, 0);
    chk("status", 0, d);
    $display("second reset test done");
    conclude;
  end
endmodule
`default_nettype wire
